// File: src/pssa_core.sv
// Product shifter, square-accumulate and product store/subtract datapath
// Operation
// - Shift-mode op copies instruction bits 1:0 into status word one bits 1:0.
// - Select 00 passes the 32-bit product unchanged.
// - Select 01 shifts product left one, zero fill.
// - Select 10 shifts product left four, zero fill.
// - Select 11 shifts product right six, sign replicated.
// - Every product op takes the shifter output; the register port reads the raw product.
// - Shift-mode op ignores sign mode; changes the select field and raises the mode event.
// - Load-status to word one also writes the select field.
// - Square-accumulate adds shifted product, saturates per mode, sets overflow and carry.
// - Then loads memory word into operand reg and squares it into product.
// - Direct address is page pointer with seven instruction bits.
// - Indirect: six pointer updates, optional next pointer 0 to 7.
`timescale 1ns/1ps
`default_nettype none
module pssa_core (
  input  wire logic                      i_clk,      // Core clock
  input  wire logic                      i_rst_n,    // Async reset, active low
  input  wire logic                      i_cmd_vld,  // Instruction issue strobe
  input  wire pssa_pkg::pssa_cmd_s       i_cmd,      // Instruction
  input  wire logic [15:0]               i_mem_rdata, // Data word for the issued op
  input  wire logic [3:0]                i_reg_addr, // Register address
  input  wire logic [15:0]               i_reg_wdata, // Register write data
  input  wire logic                      i_reg_wr,   // Register write strobe
  input  wire logic                      i_reg_rd,   // Register read strobe
  output logic [15:0]                    o_reg_rdata, // Read data, cycle after strobe
  output pssa_pkg::pssa_mem_s            o_mem,      // Data-memory request
  output logic                           o_irq       // Level interrupt
);
  import pssa_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_s1_q;
  logic rst_s2_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_n = rst_s2_q;

  //////////////////////////////////////////////////////////////////////////
  // State
  logic [W_ACC-1:0]  acc_q, acc_d;
  logic [W_ACC-1:0]  prod_q, prod_d;
  logic [W_DATA-1:0] oper_q, oper_d;
  logic [1:0]        pss_q, pss_d;
  logic              ovf_q, ovf_d;
  logic              carry_q, carry_d;
  logic [CT_W-1:0]   ctrl_q, ctrl_d;
  logic [W_DP-1:0]   dp_q, dp_d;
  logic [W_ARP-1:0]  arp_q, arp_d;
  logic [W_DATA-1:0] aux_q [N_AUX];
  logic [W_DATA-1:0] aux_d [N_AUX];
  logic [N_EV-1:0]   ist_q, ist_d;
  logic [N_EV-1:0]   imsk_q, imsk_d;
  logic [15:0]       rdata_q, rdata_d;
  pssa_mem_s         mem_q, mem_d;
  logic              irq_q, irq_d;

  //////////////////////////////////////////////////////////////////////////
  // Product shifter; right-six sign extends whatever the sign mode says
  logic [W_ACC-1:0] prod_sh;
  always_comb begin
    unique case (pss_q)
      PSS_NONE:   prod_sh = prod_q;
      PSS_LEFT1:  prod_sh = prod_q << SH_L1;
      PSS_LEFT4:  prod_sh = prod_q << SH_L4;
      PSS_RIGHT6: prod_sh = W_ACC'($signed(prod_q) >>> SH_R6);
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Operand address: direct page+offset, or current aux pointer
  logic             ind;
  logic [2:0]       aru;
  logic [W_ADDR-1:0] ea;
  logic [W_ADDR-1:0] ar_cur;
  logic [W_ADDR-1:0] ar0;
  assign ind    = i_cmd.iword[IW_IND_BIT];
  assign aru    = i_cmd.iword[IW_ARU_MSB:IW_ARU_LSB];
  assign ar_cur = aux_q[arp_q];
  assign ar0    = aux_q[0];
  assign ea = ind ? ar_cur : W_ADDR'({dp_q, i_cmd.iword[W_DMA-1:0]});

  // Bit reversal, used by the reverse-carry updates
  function automatic logic [W_ADDR-1:0] rev(input logic [W_ADDR-1:0] v);
    for (int b = 0; b < W_ADDR; b++) rev[b] = v[W_ADDR-1-b];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Accumulate with saturation; sub selects subtraction
  function automatic logic [W_ACC+2:0] acc_op(input logic [W_ACC-1:0] a,
                                              input logic [W_ACC-1:0] b,
                                              input logic sub,
                                              input logic sat);
    logic [W_ACC:0]   s;
    logic             ovr;
    logic [W_ACC-1:0] r;
    s  = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
    ovr = sub ? ((a[W_ACC-1] != b[W_ACC-1]) && (s[W_ACC-1] != a[W_ACC-1]))
              : ((a[W_ACC-1] == b[W_ACC-1]) && (s[W_ACC-1] != a[W_ACC-1]));
    r  = s[W_ACC-1:0];
    // Clip toward the accumulator's sign so a runaway sum cannot wrap
    if (ovr && sat) r = a[W_ACC-1] ? {1'b1, {(W_ACC-1){1'b0}}} : {1'b0, {(W_ACC-1){1'b1}}};
    // Carry means no borrow on subtract
    acc_op = {ovr, sub ? ~s[W_ACC] : s[W_ACC], r, 1'b0};
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Instruction execution and register writes
  logic [W_ACC+2:0] alu;
  logic             use_mem;
  logic             ev_mode;
  logic [W_ACC-1:0] sq_op;
  always_comb begin
    acc_d   = acc_q;
    prod_d  = prod_q;
    oper_d  = oper_q;
    pss_d   = pss_q;
    ovf_d   = ovf_q;
    carry_d = carry_q;
    ctrl_d  = ctrl_q;
    dp_d    = dp_q;
    arp_d   = arp_q;
    aux_d   = aux_q;
    mem_d   = '0;
    ev_mode = 1'b0;
    use_mem = 1'b0;
    // Widen first so the square keeps its upper half and its sign
    sq_op   = W_ACC'($signed(i_mem_rdata));
    alu = acc_op(acc_q, prod_sh, i_cmd.op == PSSA_OP_SUB_PROD, ctrl_q[CT_SAT]);
    if (i_cmd_vld) begin
      unique case (i_cmd.op)
        // select field and mode event only, sign mode not consulted
        PSSA_OP_SHIFT_MODE: begin
          pss_d   = i_cmd.iword[SW1_PSS_MSB:SW1_PSS_LSB];
          ev_mode = 1'b1;
        end
        PSSA_OP_LOAD_STATUS: begin
          if (i_cmd.iword[0] == LDST_WORD_ONE) begin
            pss_d   = i_cmd.operand[SW1_PSS_MSB:SW1_PSS_LSB];
            ev_mode = 1'b1;
          end
        end
        PSSA_OP_SQUARE_ACC: begin
          acc_d   = alu[W_ACC:1];
          carry_d = alu[W_ACC+1];
          ovf_d   = ovf_q | alu[W_ACC+2];
          oper_d  = i_mem_rdata;
          prod_d  = sq_op * sq_op;
          use_mem = 1'b1;
        end
        PSSA_OP_STORE_HIGH, PSSA_OP_STORE_LOW: begin
          mem_d.wr    = 1'b1;
          mem_d.addr  = ea;
          mem_d.wdata = (i_cmd.op == PSSA_OP_STORE_HIGH) ? prod_sh[W_ACC-1:W_DATA]
                                                          : prod_sh[W_DATA-1:0];
          use_mem     = 1'b1;
        end
        PSSA_OP_SUB_PROD: begin
          acc_d   = alu[W_ACC:1];
          carry_d = alu[W_ACC+1];
          ovf_d   = ovf_q | alu[W_ACC+2];
        end
        default: ;
      endcase
      if (i_cmd.op == PSSA_OP_SQUARE_ACC) begin
        mem_d.rd   = 1'b1;
        mem_d.addr = ea;
      end
      // indirect pointer update and next pointer
      if (use_mem && ind) begin
        unique case (aru)
          ARU_DEC:   aux_d[arp_q] = ar_cur - W_ADDR'(1);
          ARU_INC:   aux_d[arp_q] = ar_cur + W_ADDR'(1);
          ARU_DEC0:  aux_d[arp_q] = ar_cur - ar0;
          ARU_INC0:  aux_d[arp_q] = ar_cur + ar0;
          ARU_BRDEC: aux_d[arp_q] = rev(rev(ar_cur) - rev(ar0));
          ARU_BRINC: aux_d[arp_q] = rev(rev(ar_cur) + rev(ar0));
          default:   aux_d[arp_q] = ar_cur;
        endcase
        if (i_cmd.iword[IW_NAR_BIT]) arp_d = i_cmd.iword[IW_NARP_MSB:0];
      end
    end
    // Software writes come last, so they win over an op on the same field
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        RA_ACC_LO:  acc_d[W_DATA-1:0]     = i_reg_wdata;
        RA_ACC_HI:  acc_d[W_ACC-1:W_DATA] = i_reg_wdata;
        RA_PROD_LO: prod_d[W_DATA-1:0]    = i_reg_wdata;
        RA_PROD_HI: prod_d[W_ACC-1:W_DATA] = i_reg_wdata;
        RA_OPER:    oper_d = i_reg_wdata;
        RA_CTRL:    ctrl_d = i_reg_wdata[CT_W-1:0];
        RA_DP:      dp_d   = i_reg_wdata[W_DP-1:0];
        default: ;
      endcase
      if (i_reg_addr >= RA_AUX0) aux_d[W_ARP'(i_reg_addr - RA_AUX0)] = i_reg_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt status: set wins over write-one-to-clear
  // Flags raise an event on their rising edge only, since overflow is sticky
  logic [N_EV-1:0] ev;
  always_comb begin
    ev = '0;
    ev[EV_OVF]   = ovf_d & ~ovf_q;
    ev[EV_CARRY] = carry_d & ~carry_q;
    ev[EV_MODE]  = ev_mode;
    ist_d  = ist_q;
    imsk_d = imsk_q;
    if (i_reg_wr && i_reg_addr == RA_IRQ_ST)  ist_d  = ist_q & ~i_reg_wdata[N_EV-1:0];
    if (i_reg_wr && i_reg_addr == RA_IRQ_MSK) imsk_d = i_reg_wdata[N_EV-1:0];
    ist_d = ist_d | ev;
    irq_d = |(ist_d & imsk_d);
  end

  //////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read zero
  // Registered, so data stands only in the cycle after the strobe
  always_comb begin
    rdata_d = '0;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        RA_ACC_LO:  rdata_d = acc_q[W_DATA-1:0];
        RA_ACC_HI:  rdata_d = acc_q[W_ACC-1:W_DATA];
        RA_PROD_LO: rdata_d = prod_q[W_DATA-1:0];
        RA_PROD_HI: rdata_d = prod_q[W_ACC-1:W_DATA];
        RA_OPER:    rdata_d = oper_q;
        RA_STW1:    rdata_d = {12'h000, carry_q, ovf_q, pss_q};
        RA_CTRL:    rdata_d = 16'(ctrl_q);
        RA_IRQ_ST:  rdata_d = 16'(ist_q);
        RA_IRQ_MSK: rdata_d = 16'(imsk_q);
        RA_DP:      rdata_d = 16'(dp_q);
        default:    rdata_d = (i_reg_addr >= RA_AUX0) ? aux_q[W_ARP'(i_reg_addr - RA_AUX0)] : '0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q   <= '0;
      prod_q  <= '0;
      oper_q  <= '0;
      pss_q   <= PSS_NONE;
      ovf_q   <= 1'b0;
      carry_q <= 1'b0;
      ctrl_q  <= '0;
      dp_q    <= '0;
      arp_q   <= '0;
      for (int k = 0; k < N_AUX; k++) aux_q[k] <= '0;
      ist_q   <= '0;
      imsk_q  <= '0;
      rdata_q <= '0;
      mem_q   <= '0;
      irq_q   <= 1'b0;
    end else begin
      acc_q   <= acc_d;
      prod_q  <= prod_d;
      oper_q  <= oper_d;
      pss_q   <= pss_d;
      ovf_q   <= ovf_d;
      carry_q <= carry_d;
      ctrl_q  <= ctrl_d;
      dp_q    <= dp_d;
      arp_q   <= arp_d;
      aux_q   <= aux_d;
      ist_q   <= ist_d;
      imsk_q  <= imsk_d;
      rdata_q <= rdata_d;
      mem_q   <= mem_d;
      irq_q   <= irq_d;
    end
  end

  // Outputs come straight from their flops
  assign o_reg_rdata = rdata_q;
  assign o_mem       = mem_q;
  assign o_irq       = irq_q;
endmodule // pssa_core
`default_nettype wire

// File: src/pssa_pkg.sv
// Package for the product shift and square-accumulate datapath slice
package pssa_pkg;
  localparam int unsigned W_DATA     = 16;
  localparam int unsigned W_ACC      = 32;
  localparam int unsigned W_ADDR     = 16;
  localparam int unsigned W_DMA      = 7;
  localparam int unsigned W_DP       = 9;
  localparam int unsigned W_ARP      = 3;
  localparam int unsigned N_AUX      = 8;
  // Product shift select encodings and shift amounts
  localparam logic [1:0]  PSS_NONE   = 2'h0;
  localparam logic [1:0]  PSS_LEFT1  = 2'h1;
  localparam logic [1:0]  PSS_LEFT4  = 2'h2;
  localparam logic [1:0]  PSS_RIGHT6 = 2'h3;
  localparam int unsigned SH_L1      = 1;
  localparam int unsigned SH_L4      = 4;
  localparam int unsigned SH_R6      = 6;
  // Status word one field positions
  localparam int unsigned SW1_PSS_LSB = 0;
  localparam int unsigned SW1_PSS_MSB = 1;
  localparam logic [0:0]  LDST_WORD_ONE = 1'h1;
  // Instruction word fields
  localparam int unsigned IW_IND_BIT  = 7;
  localparam int unsigned IW_NAR_BIT  = 3;
  localparam int unsigned IW_ARU_LSB  = 4;
  localparam int unsigned IW_ARU_MSB  = 6;
  localparam int unsigned IW_NARP_MSB = 2;
  // Indirect pointer update options
  localparam logic [2:0]  ARU_NONE   = 3'h0;
  localparam logic [2:0]  ARU_DEC    = 3'h1;
  localparam logic [2:0]  ARU_INC    = 3'h2;
  localparam logic [2:0]  ARU_BRDEC  = 3'h4;
  localparam logic [2:0]  ARU_DEC0   = 3'h5;
  localparam logic [2:0]  ARU_INC0   = 3'h6;
  localparam logic [2:0]  ARU_BRINC  = 3'h7;
  // Interrupt status bit positions
  localparam int unsigned EV_OVF     = 0;
  localparam int unsigned EV_CARRY   = 1;
  localparam int unsigned EV_MODE    = 2;
  localparam int unsigned N_EV       = 3;
  // Register port offsets
  localparam logic [3:0]  RA_ACC_LO  = 4'h0;
  localparam logic [3:0]  RA_ACC_HI  = 4'h1;
  localparam logic [3:0]  RA_PROD_LO = 4'h2;
  localparam logic [3:0]  RA_PROD_HI = 4'h3;
  localparam logic [3:0]  RA_OPER    = 4'h4;
  localparam logic [3:0]  RA_STW1    = 4'h5;
  localparam logic [3:0]  RA_CTRL    = 4'h6;
  localparam logic [3:0]  RA_IRQ_ST  = 4'h7;
  localparam logic [3:0]  RA_IRQ_MSK = 4'h8;
  localparam logic [3:0]  RA_DP      = 4'h9;
  localparam logic [3:0]  RA_AUX0    = 4'ha;
  // Control register bits
  localparam int unsigned CT_SIGN    = 0;
  localparam int unsigned CT_SAT     = 1;
  localparam int unsigned CT_W       = 2;

  // Operations presented on the command port
  typedef enum logic [2:0] {
    PSSA_OP_NOP,
    PSSA_OP_SHIFT_MODE,
    PSSA_OP_LOAD_STATUS,
    PSSA_OP_SQUARE_ACC,
    PSSA_OP_STORE_HIGH,
    PSSA_OP_STORE_LOW,
    PSSA_OP_SUB_PROD
  } pssa_op_e;

  // One issued instruction
  typedef struct packed {
    pssa_op_e            op;
    logic [W_DATA-1:0]   iword;
    logic [W_DATA-1:0]   operand;
  } pssa_cmd_s;

  // Data-memory access request
  typedef struct packed {
    logic                rd;
    logic                wr;
    logic [W_ADDR-1:0]   addr;
    logic [W_DATA-1:0]   wdata;
  } pssa_mem_s;
endpackage

// File: verif/pssa_monitor.sv
// Port-level checker for the product shift and square-accumulate slice
`timescale 1ns/1ps
`default_nettype none
module pssa_monitor
  import pssa_pkg::*;
(
  input wire logic                i_clk,       // Core clock
  input wire logic                i_rst_n,     // Async reset, active low
  input wire logic                i_cmd_vld,   // Issue strobe
  input wire pssa_pkg::pssa_cmd_s i_cmd,       // Instruction
  input wire logic [15:0]         i_mem_rdata, // Data word
  input wire logic [3:0]          i_reg_addr,  // Register address
  input wire logic [15:0]         i_reg_wdata, // Register write data
  input wire logic                i_reg_wr,    // Write strobe
  input wire logic                i_reg_rd,    // Read strobe
  input wire logic [15:0]         o_reg_rdata, // Read data
  input wire pssa_pkg::pssa_mem_s o_mem,       // Memory request
  input wire logic                o_irq        // Interrupt level
);
  // One clock domain, so one default clocking and reset guard
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // Memory request timing per operation
  a_square_reads: assert property (
    i_cmd_vld && i_cmd.op == PSSA_OP_SQUARE_ACC |=> o_mem.rd && !o_mem.wr)
    else $error("square op gave no memory read");
  a_direct_addr: assert property (
    i_cmd_vld && i_cmd.op == PSSA_OP_SQUARE_ACC && !i_cmd.iword[7]
    |=> o_mem.addr[6:0] == $past(i_cmd.iword[6:0]))
    else $error("direct address low bits differ from instruction");
  a_store_writes: assert property (
    i_cmd_vld && (i_cmd.op == PSSA_OP_STORE_HIGH || i_cmd.op == PSSA_OP_STORE_LOW) |=> o_mem.wr && !o_mem.rd)
    else $error("store op gave no memory write");
  a_mode_quiet: assert property (
    i_cmd_vld && i_cmd.op == PSSA_OP_SHIFT_MODE |=> !o_mem.rd && !o_mem.wr)
    else $error("shift mode load touched memory");
  a_mem_idle: assert property (!i_cmd_vld |=> !o_mem.rd && !o_mem.wr)
    else $error("memory request without an issue");

  ////////////////////////////////////////////////////////////////////////////
  // Select field readback after a load, with the bench spacing of two cycles
  a_mode_read: assert property (
    i_cmd_vld && i_cmd.op == PSSA_OP_SHIFT_MODE ##2 i_reg_rd && i_reg_addr == RA_STW1
    |=> o_reg_rdata[1:0] == $past(i_cmd.iword[1:0], 3))
    else $error("select field not taken from instruction");
  a_status_load: assert property (
    i_cmd_vld && i_cmd.op == PSSA_OP_LOAD_STATUS && i_cmd.iword[0] ##2 i_reg_rd && i_reg_addr == RA_STW1
    |=> o_reg_rdata[1:0] == $past(i_cmd.operand[1:0], 3))
    else $error("status load did not set the select field");

  ////////////////////////////////////////////////////////////////////////////
  // Register port and interrupt behaviour
  a_rdata_idle: assert property (!i_reg_rd |=> o_reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  a_irq_masked: assert property (
    i_reg_wr && i_reg_addr == RA_IRQ_MSK && i_reg_wdata == 16'h0000 |-> ##[1:3] !o_irq)
    else $error("interrupt stays high with all masked");
endmodule // pssa_monitor

bind pssa_core pssa_monitor u_mon (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_vld(i_cmd_vld), .i_cmd(i_cmd),
  .i_mem_rdata(i_mem_rdata), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_mem(o_mem), .o_irq(o_irq));
`default_nettype wire

// File: verif/pssa_bench.sv
// Self-checking bench for the product shift and square-accumulate slice
`timescale 1ns/1ps
`default_nettype none
module product_shift_square_accumulate_bench;
  import pssa_pkg::*;
  logic        i_clk;
  logic        i_rst_n     = 1'b0;
  logic        i_cmd_vld   = 1'b0;
  pssa_cmd_s   i_cmd       = '0;
  logic [15:0] i_mem_rdata = 16'h0000;
  logic [3:0]  i_reg_addr  = 4'h0;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic        i_reg_wr    = 1'b0;
  logic        i_reg_rd    = 1'b0;
  logic [15:0] o_reg_rdata;
  pssa_mem_s   o_mem;
  logic        o_irq;
  int          error_cnt   = 0;
  int          tests_run   = 0;

  pssa_core u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_vld(i_cmd_vld), .i_cmd(i_cmd),
    .i_mem_rdata(i_mem_rdata), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_mem(o_mem), .o_irq(o_irq));

  // 125 MHz core clock
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, compare and bus helpers
  task automatic summarize();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  // Strobes drop on the next edge so back-to-back calls never collide
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1 chk(nm, 32'(e), 32'(o_reg_rdata));
  endtask
  task automatic wr32(input logic [3:0] a, input logic [31:0] d);
    wr(a, d[15:0]);
    wr(a + 4'h1, d[31:16]);
  endtask
  task automatic rd32(input logic [3:0] a, input logic [31:0] e, input string nm);
    rd(a, e[15:0], nm);
    rd(a + 4'h1, e[31:16], nm);
  endtask
  // Memory request is sampled in the cycle after the issue edge
  task automatic cmd(input pssa_op_e op, input logic [15:0] iw, input logic [15:0] opnd, input logic [15:0] md);
    @(posedge i_clk);
    i_cmd_vld <= 1'b1;
    i_cmd <= '{op: op, iword: iw, operand: opnd};
    i_mem_rdata <= md;
    @(posedge i_clk);
    i_cmd_vld <= 1'b0;
    #1;
  endtask
  // Expected shifter output
  function automatic logic [31:0] shf(input logic [31:0] p, input logic [1:0] m);
    case (m)
      2'h0: shf = p;
      2'h1: shf = p << 1;
      2'h2: shf = p << 4;
      default: shf = 32'($signed(p) >>> 6);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  // Every select code, seen through both store halves, sign mode off
  task automatic t_modes();
    logic [31:0] s;
    wr(RA_CTRL, 16'h0000);
    wr32(RA_PROD_LO, 32'h8765_4321);
    for (int m = 0; m < 4; m++) begin
      s = shf(32'h8765_4321, 2'(m));
      cmd(PSSA_OP_SHIFT_MODE, 16'hbe00 | 16'(m), 16'h0000, 16'h0000);
      rd(RA_STW1, 16'(m), "select field");
      cmd(PSSA_OP_STORE_HIGH, 16'h8d00, 16'h0000, 16'h0000);
      chk("store high", 32'(s[31:16]), 32'(o_mem.wdata));
      cmd(PSSA_OP_STORE_LOW, 16'h8c00, 16'h0000, 16'h0000);
      chk("store low", 32'(s[15:0]), 32'(o_mem.wdata));
    end
    rd32(RA_PROD_LO, 32'h8765_4321, "product kept");
    wr(RA_CTRL, 16'h0001);
    cmd(PSSA_OP_SHIFT_MODE, 16'hbe02, 16'h0000, 16'h0000);
    rd(RA_STW1, 16'h0002, "select with sign mode");
    rd(RA_CTRL, 16'h0001, "control kept");
  endtask
  // Status load acts on word one only
  task automatic t_ldst();
    cmd(PSSA_OP_LOAD_STATUS, 16'h0001, 16'h0001, 16'h0000);
    rd(RA_STW1, 16'h0001, "status load word one");
    cmd(PSSA_OP_LOAD_STATUS, 16'h0000, 16'h0002, 16'h0000);
    rd(RA_STW1, 16'h0001, "status load word zero");
  endtask
  // Direct square-accumulate with a left-one product
  task automatic t_sqa();
    wr(RA_CTRL, 16'h0000);
    cmd(PSSA_OP_SHIFT_MODE, 16'hbe01, 16'h0000, 16'h0000);
    wr32(RA_PROD_LO, 32'h0000_0080);
    wr32(RA_ACC_LO, 32'h0000_0010);
    wr(RA_DP, 16'h0003);
    cmd(PSSA_OP_SQUARE_ACC, 16'h5215, 16'h0000, 16'hfff0);
    chk("read strobe", 32'h1, 32'(o_mem.rd));
    chk("direct address", 32'h0195, 32'(o_mem.addr));
    rd32(RA_ACC_LO, 32'h0000_0110, "accumulated");
    rd(RA_OPER, 16'hfff0, "operand");
    rd32(RA_PROD_LO, 32'h0000_0100, "square");
  endtask
  // Saturating add, overflow event raised, masked and cleared
  task automatic t_sat();
    wr(RA_CTRL, 16'h0002);
    cmd(PSSA_OP_SHIFT_MODE, 16'hbe00, 16'h0000, 16'h0000);
    wr32(RA_ACC_LO, 32'h7fff_ffff);
    wr32(RA_PROD_LO, 32'h0000_0001);
    wr(RA_IRQ_ST, 16'h0007);
    wr(RA_IRQ_MSK, 16'h0001);
    cmd(PSSA_OP_SQUARE_ACC, 16'h5201, 16'h0000, 16'h0000);
    rd32(RA_ACC_LO, 32'h7fff_ffff, "saturated");
    rd(RA_STW1, 16'h0004, "overflow flag");
    rd(RA_IRQ_ST, 16'h0001, "irq status");
    chk("irq raised", 32'h1, 32'(o_irq));
    wr(RA_IRQ_MSK, 16'h0000);
    repeat (2) @(posedge i_clk);
    #1 chk("irq masked", 32'h0, 32'(o_irq));
    wr(RA_IRQ_ST, 16'h0001);
    wr(RA_IRQ_MSK, 16'h0001);
    rd(RA_IRQ_ST, 16'h0000, "irq cleared");
    chk("irq low", 32'h0, 32'(o_irq));
  endtask
  // Indirect access: post-increment with pointer change, then decrement
  task automatic t_ind();
    wr(RA_AUX0, 16'h0200);
    wr(RA_AUX0 + 4'h1, 16'h0300);
    cmd(PSSA_OP_SQUARE_ACC, {8'h52, 1'b1, ARU_INC, 1'b1, 3'h1}, 16'h0000, 16'h0002);
    chk("indirect address", 32'h0200, 32'(o_mem.addr));
    rd(RA_AUX0, 16'h0201, "pointer incremented");
    cmd(PSSA_OP_SQUARE_ACC, {8'h52, 1'b1, ARU_DEC, 1'b0, 3'h0}, 16'h0000, 16'h0002);
    chk("next pointer address", 32'h0300, 32'(o_mem.addr));
    rd(RA_AUX0 + 4'h1, 16'h02ff, "pointer decremented");
  endtask
  // Subtract a negative product through the right-six shifter
  task automatic t_sub();
    wr(RA_CTRL, 16'h0000);
    cmd(PSSA_OP_SHIFT_MODE, 16'hbe03, 16'h0000, 16'h0000);
    wr32(RA_PROD_LO, 32'hffff_ff00);
    wr32(RA_ACC_LO, 32'h0000_0010);
    cmd(PSSA_OP_SUB_PROD, 16'hbe90, 16'h0000, 16'h0000);
    rd32(RA_ACC_LO, 32'h0000_0014, "subtracted");
    // A small positive product leaves no borrow, so carry rises
    wr32(RA_PROD_LO, 32'h0000_0100);
    cmd(PSSA_OP_SUB_PROD, 16'hbe90, 16'h0000, 16'h0000);
    rd32(RA_ACC_LO, 32'h0000_0010, "subtracted again");
    rd(RA_STW1, 16'h000f, "carry after subtract");
    rd(RA_IRQ_ST, 16'h0006, "mode and carry events");
    chk("irq kept masked", 32'h0, 32'(o_irq));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for three cycles, let the internal release settle
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    t_modes();
    t_ldst();
    t_sqa();
    t_sat();
    t_ind();
    t_sub();
    summarize();
  end
  // Watchdog, far beyond the roughly 170 cycles the run needs
  initial begin
    #20000;
    error_cnt++;
    summarize();
  end
endmodule // product_shift_square_accumulate_bench
`default_nettype wire
